// *** mcu_rotate_subtract_skip_exec_bench.sv ***
// Purpose: self-checking bench for the executor over APB
// Assumes: each row preloads acc, carry and one data byte, then runs one instruction
// Notes: row status is skip, ov, z, ac, c from msb down
`timescale 1ns/1ps
`include "mrse_map.svh"
module mcu_rotate_subtract_skip_exec_bench;
  typedef struct {
    logic [4:0] op;
    logic [7:0] m;
    logic [7:0] a;
    logic c;
    logic [7:0] x;
    logic [7:0] ea;
    logic [7:0] em;
    logic [4:0] es;
  } mrse_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int num_checks = 0;
  mrse_row_t rows [28];
  always #25 pclk = ~pclk;
  mrse_top mrse_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read just after an edge, pready is the value that edge sampled; a hang is left to the watchdog
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h00000000);
    check(what, rd, exp);
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    rows = '{
      '{5'h00, 8'h81, 8'h00, 1'b1, 8'h00, 8'h03, 8'h81, 5'h01},
      '{5'h01, 8'h81, 8'h00, 1'b0, 8'h00, 8'h00, 8'h02, 5'h01},
      '{5'h02, 8'h40, 8'h00, 1'b1, 8'h00, 8'h81, 8'h40, 5'h00},
      '{5'h03, 8'h01, 8'h00, 1'b1, 8'h00, 8'h00, 8'h80, 5'h01},
      '{5'h04, 8'h03, 8'h00, 1'b0, 8'h00, 8'h81, 8'h03, 5'h00},
      '{5'h05, 8'h01, 8'h55, 1'b0, 8'h00, 8'h55, 8'h00, 5'h01},
      '{5'h06, 8'h02, 8'h00, 1'b1, 8'h00, 8'h81, 8'h02, 5'h00},
      '{5'h07, 8'h01, 8'h10, 1'b0, 8'h00, 8'h0E, 8'h01, 5'h01},
      '{5'h08, 8'h01, 8'h80, 1'b1, 8'h00, 8'h80, 8'h7F, 5'h09},
      '{5'h09, 8'h05, 8'h05, 1'b0, 8'h00, 8'h00, 8'h05, 5'h07},
      '{5'h0A, 8'h02, 8'h01, 1'b1, 8'h00, 8'h01, 8'hFF, 5'h00},
      '{5'h0B, 8'h33, 8'h20, 1'b0, 8'h01, 8'h1F, 8'h33, 5'h01},
      '{5'h0C, 8'h01, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 5'h10},
      '{5'h0D, 8'h05, 8'h00, 1'b1, 8'h00, 8'h04, 8'h05, 5'h01},
      '{5'h0E, 8'hFF, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 5'h10},
      '{5'h0F, 8'hFF, 8'h33, 1'b0, 8'h00, 8'h00, 8'hFF, 5'h10},
      '{5'h10, 8'h12, 8'h00, 1'b0, 8'h00, 8'h00, 8'hFF, 5'h00},
      '{5'h11, 8'h00, 8'h00, 1'b0, 8'h05, 8'h00, 8'h20, 5'h00},
      '{5'h12, 8'h80, 8'h00, 1'b0, 8'h07, 8'h00, 8'h80, 5'h10},
      '{5'h13, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 5'h10},
      '{5'h14, 8'h5A, 8'h00, 1'b0, 8'h00, 8'h5A, 8'h5A, 5'h00},
      '{5'h15, 8'hF7, 8'h00, 1'b0, 8'h03, 8'h00, 8'hF7, 5'h10},
      '{5'h16, 8'hA5, 8'h00, 1'b0, 8'h00, 8'h00, 8'h5A, 5'h00},
      '{5'h17, 8'h3C, 8'h00, 1'b0, 8'h00, 8'hC3, 8'h3C, 5'h00},
      '{5'h1A, 8'hF0, 8'hF0, 1'b1, 8'h00, 8'h00, 8'hF0, 5'h05},
      '{5'h1B, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h0F, 8'hFF, 5'h00},
      '{5'h1C, 8'h11, 8'hAA, 1'b0, 8'hAA, 8'h00, 8'h11, 5'h04},
      '{5'h1D, 8'h34, 8'h12, 1'b1, 8'h00, 8'h12, 8'h34, 5'h01}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`MRSE_OFF_ACC, 32'h00000000, "reset acc");
    rd_chk(`MRSE_OFF_STATUS, 32'h00000000, "reset status");
    rd_chk(`MRSE_OFF_INFO, 32'h00000000, "reset cycles");
    rd_chk(`MRSE_OFF_PAGE, 32'h00000000, "reset page");
    foreach (rows[i])
    begin
      xfer(1'b1, `MRSE_OFF_ACC, {24'h000000, rows[i].a});
      xfer(1'b1, `MRSE_OFF_STATUS, {31'h00000000, rows[i].c});
      xfer(1'b1, `MRSE_OFF_DADDR, 32'h00000010);
      xfer(1'b1, `MRSE_OFF_DDATA, {24'h000000, rows[i].m});
      // instruction runs back to back with the first read, which must stall
      xfer(1'b1, `MRSE_OFF_INSTR, {rows[i].x, 8'h10, 5'h00, rows[i].x[2:0], 3'h0, rows[i].op});
      rd_chk(`MRSE_OFF_ACC, {24'h000000, rows[i].ea}, "acc");
      rd_chk(`MRSE_OFF_DDATA, {24'h000000, rows[i].em}, "mem");
      rd_chk(`MRSE_OFF_STATUS, {27'h0000000, rows[i].es}, "status");
      rd_chk(`MRSE_OFF_INFO, rows[i].es[4] ? 32'h00000002 : 32'h00000001, "cycles");
    end
    xfer(1'b1, `MRSE_OFF_PAGE, 32'h00000003);
    xfer(1'b1, `MRSE_OFF_TPTR, 32'h00000045);
    xfer(1'b1, `MRSE_OFF_PADDR, 32'h00000345);
    xfer(1'b1, `MRSE_OFF_PDATA, 32'h00003C5A);
    xfer(1'b1, `MRSE_OFF_PADDR, 32'h00000F45);
    xfer(1'b1, `MRSE_OFF_PDATA, 32'h00007181);
    xfer(1'b1, `MRSE_OFF_STATUS, 32'h00000001);
    xfer(1'b1, `MRSE_OFF_DADDR, 32'h00000020);
    xfer(1'b1, `MRSE_OFF_INSTR, 32'h00200018);
    rd_chk(`MRSE_OFF_DDATA, 32'h0000005A, "table low");
    rd_chk(`MRSE_OFF_THIGH, 32'h0000003C, "table high");
    xfer(1'b1, `MRSE_OFF_INSTR, 32'h00200019);
    rd_chk(`MRSE_OFF_DDATA, 32'h00000081, "last low");
    rd_chk(`MRSE_OFF_THIGH, 32'h00000071, "last high");
    rd_chk(`MRSE_OFF_STATUS, 32'h00000001, "table flags");
    xfer(1'b1, `MRSE_OFF_THIGH, 32'h00000000);
    rd_chk(`MRSE_OFF_THIGH, 32'h00000071, "high read only");
    xfer(1'b1, `MRSE_OFF_DADDR, 32'h000000A0);
    check("daddr refused", {31'h00000000, er}, 32'h00000001);
    rd_chk(`MRSE_OFF_DADDR, 32'h00000020, "daddr kept");
    xfer(1'b1, `MRSE_OFF_INSTR, 32'h00A00010);
    check("instr refused", {31'h00000000, er}, 32'h00000001);
    rd_chk(`MRSE_OFF_DDATA, 32'h00000081, "refused instr no effect");
    rd_chk(12'h02C, 32'h00000000, "unmapped data");
    check("unmapped refused", {31'h00000000, er}, 32'h00000001);
    wrap_up();
  end
endmodule // mcu_rotate_subtract_skip_exec_bench

// *** mrse_chk.sv ***
// Purpose: bus-level checks of the executor top
// Assumes: one clock domain, master holds requests until pready
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`include "mrse_map.svh"
module mrse_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic fresh_q;
  logic ran_q;
  logic skip_q;
  wire done = psel && penable && pready && !pslverr;
  wire instr_wr = done && pwrite && paddr == `MRSE_OFF_INSTR;
  wire stat_rd = done && !pwrite && paddr == `MRSE_OFF_STATUS;
  wire info_rd = done && !pwrite && paddr == `MRSE_OFF_INFO;
  wire high_rd = done && !pwrite && paddr == `MRSE_OFF_THIGH;
  // status must be read after the last instruction before its skip bit says anything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fresh_q <= 1'b0;
      ran_q <= 1'b0;
      skip_q <= 1'b0;
    end
    else
    begin
      fresh_q <= instr_wr ? 1'b0 : (stat_rd ? 1'b1 : fresh_q);
      ran_q <= ran_q || instr_wr;
      skip_q <= stat_rd ? prdata[`MRSE_ST_SKIP] : skip_q;
    end
  end
  ready_in_access_a: assert property (pready |-> psel && penable) // apb
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready) // apb
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready) // apb
    else $error("pslverr without pready");
  rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h00000000) // apb
    else $error("prdata not zero outside read answer");
  answer_bound_a: assert property (psel && penable && !pready |-> ##[1:12] pready) // apb
    else $error("no answer within twelve cycles");
  bad_addr_err_a: assert property (pready && paddr > `MRSE_OFF_INFO |-> pslverr) // apb
    else $error("unmapped address not refused");
  status_upper_a: assert property (stat_rd |-> prdata[31:5] == 27'h0000000)
    else $error("status busy or upper bits set");
  high_byte_a: assert property (high_rd |-> prdata[31:7] == 25'h0000000)
    else $error("table high byte wider than seven bits");
  skip_cycles_a: assert property (info_rd && ran_q && fresh_q |->
    prdata == (skip_q ? 32'h00000002 : 32'h00000001))
    else $error("cycle count does not match skip");
  cover property (info_rd && fresh_q && skip_q);
  cover property (pslverr);
  cover property (instr_wr);
endmodule // mrse_chk
bind mrse_top mrse_chk mrse_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** mrse_map.svh ***
// Purpose: register map, field positions, opcode codes and reset values of the executor
// Assumes: included by its bare name; definitions only
// Notes: every byte offset is one aligned 32-bit word on the APB bus
`ifndef MRSE_MAP_SVH
`define MRSE_MAP_SVH
`define MRSE_OFF_INSTR 12'h000
`define MRSE_OFF_ACC 12'h004
`define MRSE_OFF_STATUS 12'h008
`define MRSE_OFF_TPTR 12'h00C
`define MRSE_OFF_THIGH 12'h010
`define MRSE_OFF_DADDR 12'h014
`define MRSE_OFF_DDATA 12'h018
`define MRSE_OFF_PADDR 12'h01C
`define MRSE_OFF_PDATA 12'h020
`define MRSE_OFF_PAGE 12'h024
`define MRSE_OFF_INFO 12'h028
`define MRSE_ST_C 0
`define MRSE_ST_AC 1
`define MRSE_ST_Z 2
`define MRSE_ST_OV 3
`define MRSE_ST_SKIP 4
`define MRSE_ST_BUSY 5
`define MRSE_DMEM_DEPTH 160
`define MRSE_DMEM_LAST 8'h9F
`define MRSE_PMEM_DEPTH 4096
`define MRSE_LAST_PAGE 4'hF
`define MRSE_ZERO_BYTE 8'h00
`define MRSE_ALL_ONES 8'hFF
`define MRSE_ONE 8'h01
`define MRSE_CYC_ONE 2'h1
`define MRSE_CYC_TWO 2'h2
`define MRSE_OP_ROT_L_ACC 5'h00
`define MRSE_OP_ROT_L_C 5'h01
`define MRSE_OP_ROT_L_C_ACC 5'h02
`define MRSE_OP_ROT_R 5'h03
`define MRSE_OP_ROT_R_ACC 5'h04
`define MRSE_OP_ROT_R_C 5'h05
`define MRSE_OP_ROT_R_C_ACC 5'h06
`define MRSE_OP_MINUS_BORROW 5'h07
`define MRSE_OP_MINUS_BORROW_MEM 5'h08
`define MRSE_OP_MINUS 5'h09
`define MRSE_OP_MINUS_INTO_MEM 5'h0A
`define MRSE_OP_MINUS_IMM 5'h0B
`define MRSE_OP_DEC_SKIP 5'h0C
`define MRSE_OP_DEC_SKIP_COPY 5'h0D
`define MRSE_OP_INC_SKIP 5'h0E
`define MRSE_OP_INC_SKIP_COPY 5'h0F
`define MRSE_OP_SET_BYTE 5'h10
`define MRSE_OP_SET_BIT 5'h11
`define MRSE_OP_SKIP_BIT_SET 5'h12
`define MRSE_OP_SKIP_ZERO 5'h13
`define MRSE_OP_SKIP_ZERO_COPY 5'h14
`define MRSE_OP_SKIP_BIT_CLR 5'h15
`define MRSE_OP_NIBBLE 5'h16
`define MRSE_OP_NIBBLE_ACC 5'h17
`define MRSE_OP_TABLE_CUR 5'h18
`define MRSE_OP_TABLE_LAST 5'h19
`define MRSE_OP_XOR 5'h1A
`define MRSE_OP_XOR_INTO_MEM 5'h1B
`define MRSE_OP_XOR_IMM 5'h1C
`endif

// *** mrse_mem.sv ***
// Purpose: single-port-write, registered-read memory
// Assumes: read address in range
// Notes: read during write returns the old word
`timescale 1ns/1ps
module mrse_mem #(
  parameter int W = 8,
  parameter int D = 160,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [0:D-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mrse_mem

// *** mrse_pkg.sv ***
// Purpose: types shared by the executor files
// Assumes: field widths match the map header
// Notes: instruction word layout is imm, addr, pad, bit, pad, op from msb down
package mrse_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_DUMMY} mrse_state_t;
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mrse_flags_t;
  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
    logic [4:0] pad_hi;
    logic [2:0] bitsel;
    logic [2:0] pad_lo;
    logic [4:0] op;
  } mrse_instr_t;
endpackage

// *** mrse_sub.sv ***
// Purpose: 8-bit subtract with carry acting as inverted borrow
// Assumes: cin high means no borrow
// Notes: purely combinational
`timescale 1ns/1ps
module mrse_sub (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] diff,
  output logic c,
  output logic ac,
  output logic ov
);
  logic [8:0] full;
  logic [4:0] low;

  assign full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
  assign low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign diff = full[7:0];
  assign c = full[8];
  assign ac = low[4];
  assign ov = (a[7] != b[7]) && (full[7] != a[7]);
endmodule // mrse_sub

// *** mrse_top.sv ***
// Purpose: executes rotate, subtract, skip, set, swap, table read and xor instructions
// Assumes: APB master keeps requests stable; one instruction at a time
// Notes: any access stalls while an instruction runs, so flags never race software
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "mrse_map.svh"

module mrse_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  mrse_pkg::mrse_state_t state_q;
  mrse_pkg::mrse_state_t state_d;
  mrse_pkg::mrse_instr_t instr_q;
  mrse_pkg::mrse_instr_t wr_instr;
  mrse_pkg::mrse_flags_t flags_q;
  mrse_pkg::mrse_flags_t flags_d;
  logic [7:0] acc_q;
  logic [7:0] tptr_q;
  logic [6:0] thigh_q;
  logic [7:0] daddr_q;
  logic [11:0] pmaddr_q;
  logic [3:0] page_q;
  logic skip_q;
  logic [1:0] cycles_q;
  logic idle_prev_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // bus decode
  logic access;
  logic fire;
  logic idle;
  logic take;
  logic wr;
  logic sel_instr;
  logic sel_acc;
  logic sel_status;
  logic sel_tptr;
  logic sel_thigh;
  logic sel_daddr;
  logic sel_ddata;
  logic sel_paddr;
  logic sel_pdata;
  logic sel_page;
  logic sel_info;
  logic mapped;
  logic bad_daddr;
  logic bad_instr;
  logic err;
  logic [31:0] rd_mux;

  // memories
  logic [7:0] dm_raddr;
  logic [7:0] dm_waddr;
  logic [7:0] dm_wdata;
  logic [7:0] dm_rdata;
  logic dm_we;
  logic [11:0] pm_raddr;
  logic [14:0] pm_rdata;
  logic pm_we;
  logic [3:0] tbl_page;

  // execution
  logic [7:0] mem_b;
  logic [7:0] sub_b;
  logic sub_cin;
  logic [7:0] sub_diff;
  logic sub_c;
  logic sub_ac;
  logic sub_ov;
  logic [7:0] bit_mask;
  logic [7:0] res;
  logic to_acc;
  logic to_mem;
  logic skip;
  logic upd_z;
  logic upd_sub;
  logic upd_c;
  logic new_c;
  logic thigh_we;
  logic exec;

  assign access = psel && penable;
  assign fire = access && pready_q;
  assign idle = (state_q == mrse_pkg::ST_IDLE);
  // wait one idle cycle so the data memory read port settles on daddr again
  assign take = access && !pready_q && idle && idle_prev_q;
  assign wr = fire && pwrite && !pslverr_q;
  assign wr_instr = mrse_pkg::mrse_instr_t'(pwdata);

  assign sel_instr = (paddr == `MRSE_OFF_INSTR);
  assign sel_acc = (paddr == `MRSE_OFF_ACC);
  assign sel_status = (paddr == `MRSE_OFF_STATUS);
  assign sel_tptr = (paddr == `MRSE_OFF_TPTR);
  assign sel_thigh = (paddr == `MRSE_OFF_THIGH);
  assign sel_daddr = (paddr == `MRSE_OFF_DADDR);
  assign sel_ddata = (paddr == `MRSE_OFF_DDATA);
  assign sel_paddr = (paddr == `MRSE_OFF_PADDR);
  assign sel_pdata = (paddr == `MRSE_OFF_PDATA);
  assign sel_page = (paddr == `MRSE_OFF_PAGE);
  assign sel_info = (paddr == `MRSE_OFF_INFO);
  assign mapped = sel_instr || sel_acc || sel_status || sel_tptr || sel_thigh || sel_daddr
    || sel_ddata || sel_paddr || sel_pdata || sel_page || sel_info;
  // out-of-range data addresses are refused rather than aliased
  assign bad_daddr = sel_daddr && pwrite && (pwdata[7:0] > `MRSE_DMEM_LAST);
  assign bad_instr = sel_instr && pwrite && (wr_instr.addr > `MRSE_DMEM_LAST);
  assign err = !mapped || bad_daddr || bad_instr;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_instr)
    begin
      rd_mux = 32'(instr_q);
    end
    else if (sel_acc)
    begin
      rd_mux = {24'h00_0000, acc_q};
    end
    else if (sel_status)
    begin
      rd_mux[`MRSE_ST_C] = flags_q.c;
      rd_mux[`MRSE_ST_AC] = flags_q.ac;
      rd_mux[`MRSE_ST_Z] = flags_q.z;
      rd_mux[`MRSE_ST_OV] = flags_q.ov;
      rd_mux[`MRSE_ST_SKIP] = skip_q;
      rd_mux[`MRSE_ST_BUSY] = !idle;
    end
    else if (sel_tptr)
    begin
      rd_mux = {24'h00_0000, tptr_q};
    end
    else if (sel_thigh)
    begin
      rd_mux = {25'h000_0000, thigh_q};
    end
    else if (sel_daddr)
    begin
      rd_mux = {24'h00_0000, daddr_q};
    end
    else if (sel_ddata)
    begin
      rd_mux = {24'h00_0000, dm_rdata};
    end
    else if (sel_paddr)
    begin
      rd_mux = {20'h0_0000, pmaddr_q};
    end
    else if (sel_pdata)
    begin
      rd_mux = {17'h0_0000, pm_rdata};
    end
    else if (sel_page)
    begin
      rd_mux = {28'h000_0000, page_q};
    end
    else if (sel_info)
    begin
      rd_mux = {30'h0000_0000, cycles_q};
    end
  end

  // apb answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      idle_prev_q <= 1'b1;
    end
    else
    begin
      pready_q <= take;
      pslverr_q <= take && err;
      prdata_q <= (take && !pwrite && !err) ? rd_mux : 32'h0000_0000;
      idle_prev_q <= idle;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tptr_q <= `MRSE_ZERO_BYTE;
      daddr_q <= `MRSE_ZERO_BYTE;
      pmaddr_q <= '0;
      page_q <= '0;
      instr_q <= '0;
    end
    else if (wr)
    begin
      if (sel_tptr)
      begin
        tptr_q <= pwdata[7:0];
      end
      if (sel_daddr)
      begin
        daddr_q <= pwdata[7:0];
      end
      if (sel_paddr)
      begin
        pmaddr_q <= pwdata[11:0];
      end
      if (sel_page)
      begin
        page_q <= pwdata[3:0];
      end
      if (sel_instr)
      begin
        instr_q <= wr_instr;
      end
    end
  end

  // memory ports: executor owns them while busy, software otherwise
  assign tbl_page = (instr_q.op == `MRSE_OP_TABLE_LAST) ? `MRSE_LAST_PAGE : page_q;
  assign dm_raddr = idle ? daddr_q : instr_q.addr;
  assign pm_raddr = idle ? pmaddr_q : {tbl_page, tptr_q};
  assign exec = (state_q == mrse_pkg::ST_EXEC);
  assign dm_we = (exec && to_mem) || (wr && sel_ddata);
  assign dm_waddr = exec ? instr_q.addr : daddr_q;
  assign dm_wdata = exec ? res : pwdata[7:0];
  assign pm_we = wr && sel_pdata;

  mrse_mem #(.W(8), .D(`MRSE_DMEM_DEPTH), .AW(8)) u_dmem (
    .clk(pclk),
    .we(dm_we),
    .waddr(dm_waddr),
    .wdata(dm_wdata),
    .raddr(dm_raddr),
    .rdata(dm_rdata)
  );

  mrse_mem #(.W(15), .D(`MRSE_PMEM_DEPTH), .AW(12)) u_pmem (
    .clk(pclk),
    .we(pm_we),
    .waddr(pmaddr_q),
    .wdata(pwdata[14:0]),
    .raddr(pm_raddr),
    .rdata(pm_rdata)
  );

  // datapath
  assign mem_b = dm_rdata;
  assign sub_b = (instr_q.op == `MRSE_OP_MINUS_IMM) ? instr_q.imm : mem_b;
  assign sub_cin = (instr_q.op == `MRSE_OP_MINUS_BORROW)
    || (instr_q.op == `MRSE_OP_MINUS_BORROW_MEM) ? flags_q.c : 1'b1;
  assign bit_mask = `MRSE_ONE << instr_q.bitsel;

  mrse_sub u_sub (
    .a(acc_q),
    .b(sub_b),
    .cin(sub_cin),
    .diff(sub_diff),
    .c(sub_c),
    .ac(sub_ac),
    .ov(sub_ov)
  );

  always_comb
  begin
    res = mem_b;
    to_acc = 1'b0;
    to_mem = 1'b0;
    skip = 1'b0;
    upd_z = 1'b0;
    upd_sub = 1'b0;
    upd_c = 1'b0;
    new_c = flags_q.c;
    thigh_we = 1'b0;
    case (instr_q.op)
      `MRSE_OP_ROT_L_ACC:
      begin
        res = {mem_b[6:0], mem_b[7]};
        to_acc = 1'b1;
      end
      `MRSE_OP_ROT_L_C, `MRSE_OP_ROT_L_C_ACC:
      begin
        res = {mem_b[6:0], flags_q.c};
        new_c = mem_b[7];
        upd_c = 1'b1;
        to_acc = (instr_q.op == `MRSE_OP_ROT_L_C_ACC);
        to_mem = !to_acc;
      end
      `MRSE_OP_ROT_R, `MRSE_OP_ROT_R_ACC:
      begin
        res = {mem_b[0], mem_b[7:1]};
        to_acc = (instr_q.op == `MRSE_OP_ROT_R_ACC);
        to_mem = !to_acc;
      end
      `MRSE_OP_ROT_R_C, `MRSE_OP_ROT_R_C_ACC:
      begin
        res = {flags_q.c, mem_b[7:1]};
        new_c = mem_b[0];
        upd_c = 1'b1;
        to_acc = (instr_q.op == `MRSE_OP_ROT_R_C_ACC);
        to_mem = !to_acc;
      end
      `MRSE_OP_MINUS_BORROW, `MRSE_OP_MINUS, `MRSE_OP_MINUS_IMM:
      begin
        res = sub_diff;
        upd_sub = 1'b1;
        to_acc = 1'b1;
      end
      `MRSE_OP_MINUS_BORROW_MEM, `MRSE_OP_MINUS_INTO_MEM:
      begin
        res = sub_diff;
        upd_sub = 1'b1;
        to_mem = 1'b1;
      end
      `MRSE_OP_DEC_SKIP, `MRSE_OP_DEC_SKIP_COPY:
      begin
        res = mem_b - `MRSE_ONE;
        skip = (res == `MRSE_ZERO_BYTE);
        to_acc = (instr_q.op == `MRSE_OP_DEC_SKIP_COPY);
        to_mem = !to_acc;
      end
      `MRSE_OP_INC_SKIP, `MRSE_OP_INC_SKIP_COPY:
      begin
        res = mem_b + `MRSE_ONE;
        skip = (res == `MRSE_ZERO_BYTE);
        to_acc = (instr_q.op == `MRSE_OP_INC_SKIP_COPY);
        to_mem = !to_acc;
      end
      `MRSE_OP_SET_BYTE:
      begin
        res = `MRSE_ALL_ONES;
        to_mem = 1'b1;
      end
      `MRSE_OP_SET_BIT:
      begin
        res = mem_b | bit_mask;
        to_mem = 1'b1;
      end
      `MRSE_OP_SKIP_BIT_SET:
      begin
        skip = |(mem_b & bit_mask);
      end
      `MRSE_OP_SKIP_ZERO, `MRSE_OP_SKIP_ZERO_COPY:
      begin
        skip = (mem_b == `MRSE_ZERO_BYTE);
        to_acc = (instr_q.op == `MRSE_OP_SKIP_ZERO_COPY);
      end
      `MRSE_OP_SKIP_BIT_CLR:
      begin
        skip = !(|(mem_b & bit_mask));
      end
      `MRSE_OP_NIBBLE, `MRSE_OP_NIBBLE_ACC:
      begin
        res = {mem_b[3:0], mem_b[7:4]};
        to_acc = (instr_q.op == `MRSE_OP_NIBBLE_ACC);
        to_mem = !to_acc;
      end
      `MRSE_OP_TABLE_CUR, `MRSE_OP_TABLE_LAST:
      begin
        res = pm_rdata[7:0];
        to_mem = 1'b1;
        thigh_we = 1'b1;
      end
      `MRSE_OP_XOR, `MRSE_OP_XOR_IMM:
      begin
        res = acc_q ^ ((instr_q.op == `MRSE_OP_XOR_IMM) ? instr_q.imm : mem_b);
        upd_z = 1'b1;
        to_acc = 1'b1;
      end
      `MRSE_OP_XOR_INTO_MEM:
      begin
        res = acc_q ^ mem_b;
        upd_z = 1'b1;
        to_mem = 1'b1;
      end
      default:
      begin
        // unused codes run as a no-operation
        res = mem_b;
      end
    endcase
  end

  always_comb
  begin
    flags_d = flags_q;
    if (upd_c)
    begin
      flags_d.c = new_c;
    end
    if (upd_sub)
    begin
      flags_d.c = sub_c;
      flags_d.ac = sub_ac;
      flags_d.ov = sub_ov;
    end
    if (upd_sub || upd_z)
    begin
      flags_d.z = (res == `MRSE_ZERO_BYTE);
    end
  end

  // sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      mrse_pkg::ST_IDLE:
      begin
        if (wr && sel_instr)
        begin
          state_d = mrse_pkg::ST_READ;
        end
      end
      mrse_pkg::ST_READ:
      begin
        state_d = mrse_pkg::ST_EXEC;
      end
      mrse_pkg::ST_EXEC:
      begin
        state_d = skip ? mrse_pkg::ST_DUMMY : mrse_pkg::ST_IDLE;
      end
      mrse_pkg::ST_DUMMY:
      begin
        state_d = mrse_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= mrse_pkg::ST_IDLE;
      skip_q <= 1'b0;
      cycles_q <= '0;
      thigh_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (exec)
      begin
        skip_q <= skip;
        cycles_q <= skip ? `MRSE_CYC_TWO : `MRSE_CYC_ONE;
      end
      if (exec && thigh_we)
      begin
        thigh_q <= pm_rdata[14:8];
      end
    end
  end

  // acc and flags: software writes only happen while idle, so no race with exec
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= `MRSE_ZERO_BYTE;
      flags_q <= '0;
    end
    else if (exec)
    begin
      if (to_acc)
      begin
        acc_q <= res;
      end
      flags_q <= flags_d;
    end
    else if (wr && sel_acc)
    begin
      acc_q <= pwdata[7:0];
    end
    else if (wr && sel_status)
    begin
      flags_q.c <= pwdata[`MRSE_ST_C];
      flags_q.ac <= pwdata[`MRSE_ST_AC];
      flags_q.z <= pwdata[`MRSE_ST_Z];
      flags_q.ov <= pwdata[`MRSE_ST_OV];
    end
  end
endmodule // mrse_top
